// [hw/pcmrx_pkg.sv]
package pcmrx_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_HZ = 125000000;
  localparam int STANDBY_MS = 300;
  localparam int STANDBY_CYCLES = STANDBY_MS * (SYS_CLK_HZ / 1000);
  localparam int SBY_W = 26;
  localparam int MIN_BCLK_HZ = 64000;
  localparam int BCLK_PERIOD_CYCLES = (SYS_CLK_HZ + MIN_BCLK_HZ - 1) / MIN_BCLK_HZ;
  localparam logic [11:0] MODE_WINDOW = 12'(2 * BCLK_PERIOD_CYCLES);
  localparam logic [1:0] STRAP_TAKE = 2'h2;
  localparam logic [1:0] STRAP_DONE = 2'h3;

  // ----------------------------------------------------------------
  // Serial word
  // ----------------------------------------------------------------
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] FS_DOUBLE = 2'h2;
  localparam logic [1:0] FS_SAT = 2'h3;

  // ----------------------------------------------------------------
  // Frequency strap codes and master clock rates in kHz
  // ----------------------------------------------------------------
  localparam logic [1:0] FSEL_NEG = 2'h0;
  localparam logic [1:0] FSEL_GND = 2'h1;
  localparam logic [1:0] FSEL_POS = 2'h2;
  localparam logic [15:0] KHZ_2048 = 16'h0800;
  localparam logic [15:0] KHZ_1544 = 16'h0608;
  localparam logic [15:0] KHZ_1536 = 16'h0600;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_WORD = 8'h08;
  localparam logic [7:0] REG_FREQ = 8'h0c;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int ST_VAR = 0;
  localparam int ST_SBY = 1;
  localparam int ST_PWR = 2;
  localparam int ST_SIG = 3;
  localparam int ST_FSEL = 4;
  localparam int ST_MODE = 6;
  localparam int WD_SIG = 8;
  localparam int WD_CNT = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {PCMRX_OFF, PCMRX_STANDBY, PCMRX_FIXED, PCMRX_VARIABLE} pcmrx_mode_t;

endpackage

// [hw/pcmrx_word_if.sv]
`timescale 1ns/10ps
interface pcmrx_word_if;
  logic [7:0] word;
  logic sig_frame;
  logic toggle;

  modport src (output word, output sig_frame, output toggle);
  modport dst (input word, input sig_frame, input toggle);
endinterface

// [hw/pcmrx_sync.sv]
`timescale 1ns/10ps
module pcmrx_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pcmrx_sync_t;

  pcmrx_sync_t s;
  pcmrx_sync_t next_s;

  // Two stages; only the second is visible outside
  always_comb
  begin
    next_s.s1 = d;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign q = s.s2;
endmodule

// [hw/pcmrx_link.sv]
`timescale 1ns/10ps
module pcmrx_link (
  input wire logic rx_master_clock,
  input wire logic rst_n,
  input wire logic rx_frame_sync,
  input wire logic rx_pcm_data,
  pcmrx_word_if.src link
);
  import pcmrx_pkg::*;

  typedef struct packed {
    logic fs_prev;
    logic [1:0] fs_len;
    logic busy;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] word;
    logic sig_frame;
    logic toggle;
  } pcmrx_link_t;

  pcmrx_link_t s;
  pcmrx_link_t next_s;

  // Fixed-rate capture on falling master clock edges
  always_comb
  begin
    next_s = s;
    next_s.fs_prev = rx_frame_sync;
    if (rx_frame_sync && !s.fs_prev)
    begin
      next_s.fs_len = 2'h1; // Pulse length in clocks
      next_s.busy = 1'b1;
      next_s.bit_cnt = 3'h1;
      next_s.shift = {7'h00, rx_pcm_data}; // First bit is the MSB
    end
    else
    begin
      if (rx_frame_sync && s.fs_len != FS_SAT)
        next_s.fs_len = s.fs_len + 2'h1;
      if (s.busy)
      begin
        next_s.shift = {s.shift[6:0], rx_pcm_data};
        next_s.bit_cnt = s.bit_cnt + 3'h1;
        if (s.bit_cnt == BIT_LAST)
        begin
          next_s.busy = 1'b0;
          next_s.word = {s.shift[6:0], rx_pcm_data};
          next_s.sig_frame = (s.fs_len >= FS_DOUBLE); // Double pulse flags signaling
          next_s.toggle = ~s.toggle; // Event crosses as a toggle
        end
      end
    end
  end

  // Data clock falls mid-bit, so sample there
  always_ff @(negedge rx_master_clock or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign link.word = s.word;
  assign link.sig_frame = s.sig_frame;
  assign link.toggle = s.toggle;
endmodule

// [hw/pcmrx_top.sv]
// Notes on behaviour
// - Eight falling data-clock edges capture one word
// - Data clock: master fixed, bit clock variable
// - Bit clock held low selects fixed timing
// - Single sync pulse plain, double pulse signaling
// - Sync low 300 ms enters standby
// - Signal output holds last signaling LSB
// - Power-down low makes the port inactive
// - Frequency strap picks 2.048/1.544/1.536 MHz
// - Master clock is bit clock only fixed
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module pcmrx_top #(
  parameter int STANDBY_CYCLES = pcmrx_pkg::STANDBY_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic rx_master_clock,
  input wire logic rx_bit_clock,
  input wire logic rx_frame_sync,
  input wire logic rx_pcm_data,
  input wire logic power_down_n,
  input wire logic [1:0] master_freq_select,
  input wire logic [pcmrx_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pcmrx_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic rx_signal_bit_out,
  output logic [7:0] rx_word,
  output logic rx_word_valid
);
  import pcmrx_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam logic [SBY_W-1:0] SBY_LAST = SBY_W'(STANDBY_CYCLES - 1);

  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic aw_held;
    logic [5:0] aw_idx;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic ctrl_en;
    logic [1:0] strap_cnt;
    logic [1:0] freq_code;
    logic bclk_prev;
    logic [11:0] mode_cnt;
    logic var_seen;
    logic [SBY_W-1:0] sby_cnt;
    logic standby;
    pcmrx_mode_t mode;
    logic [2:0] var_cnt;
    logic [7:0] var_shift;
    logic tog_seen;
    logic [7:0] word;
    logic word_sig;
    logic word_valid;
    logic sig_bit;
    logic [15:0] word_count;
  } pcmrx_top_t;

  pcmrx_top_t s;
  pcmrx_top_t next_s;

  // ----------------------------------------------------------------
  // Link side and pin synchronisers
  // ----------------------------------------------------------------
  pcmrx_word_if link_if ();

  logic [6:0] sync_q;
  logic bclk_q;
  logic fs_q;
  logic dat_q;
  logic pdn_q;
  logic [1:0] fsel_q;
  logic tog_q;
  logic [15:0] freq_khz;

  // Fixed-rate capture runs on the master clock itself
  pcmrx_link u_link (
    .rx_master_clock(rx_master_clock),
    .rst_n(rst_n),
    .rx_frame_sync(rx_frame_sync),
    .rx_pcm_data(rx_pcm_data),
    .link(link_if.src)
  );

  // Bit clock, sync, data, power-down, strap and the link toggle pass two flops first
  pcmrx_sync #(
    .W(7)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d({link_if.toggle, master_freq_select, power_down_n, rx_pcm_data, rx_frame_sync, rx_bit_clock}),
    .q(sync_q)
  );

  assign {tog_q, fsel_q, pdn_q, dat_q, fs_q, bclk_q} = sync_q;

  // Strap code to master clock rate
  always_comb
  begin
    unique case (s.freq_code)
      FSEL_GND: freq_khz = KHZ_1544;
      FSEL_POS: freq_khz = KHZ_1536;
      default: freq_khz = KHZ_2048; // Unused code reads as the negative strap
    endcase
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;

    // Write address and data are taken independently
    if (s.awready && s_axi_awvalid)
    begin
      next_s.aw_held = 1'b1;
      next_s.aw_idx = s_axi_awaddr[7:2];
    end
    if (s.wready && s_axi_wvalid)
    begin
      next_s.w_held = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready)
      next_s.bvalid = 1'b0;

    // Perform the write once both halves are held
    if (s.aw_held && s.w_held && !s.bvalid)
    begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      if (s.aw_idx == REG_CTRL[7:2])
      begin
        if (s.wstrb[0])
          next_s.ctrl_en = s.wdata[0];
      end
      else if (s.aw_idx != REG_STATUS[7:2] && s.aw_idx != REG_WORD[7:2] && s.aw_idx != REG_FREQ[7:2])
        next_s.bresp = RESP_SLVERR; // Read-only words accept and ignore writes
    end

    // Read answer one cycle after the address is taken
    if (s.rvalid && s_axi_rready)
      next_s.rvalid = 1'b0;
    if (s.arready && s_axi_arvalid)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = '0;
      case (s_axi_araddr[7:2])
        REG_CTRL[7:2]:
          next_s.rdata[0] = s.ctrl_en;
        REG_STATUS[7:2]:
        begin
          next_s.rdata[ST_VAR] = s.var_seen;
          next_s.rdata[ST_SBY] = s.standby;
          next_s.rdata[ST_PWR] = pdn_q;
          next_s.rdata[ST_SIG] = s.sig_bit;
          next_s.rdata[ST_FSEL +: 2] = s.freq_code;
          next_s.rdata[ST_MODE +: 2] = s.mode;
        end
        REG_WORD[7:2]:
        begin
          next_s.rdata[7:0] = s.word;
          next_s.rdata[WD_SIG] = s.word_sig;
          next_s.rdata[WD_CNT +: 16] = s.word_count;
        end
        REG_FREQ[7:2]:
          next_s.rdata[15:0] = freq_khz;
        default:
          next_s.rresp = RESP_SLVERR;
      endcase
    end

    // Ready flags registered so the ports come from flops
    next_s.awready = !next_s.aw_held && !next_s.bvalid;
    next_s.wready = !next_s.w_held && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;

    // Strap is a static level; catch it shortly after reset release
    if (s.strap_cnt != STRAP_DONE)
      next_s.strap_cnt = s.strap_cnt + 2'h1;
    if (s.strap_cnt == STRAP_TAKE)
      next_s.freq_code = fsel_q;

    // A toggling bit clock means variable timing; held low means fixed.
    // The window spans two periods of the slowest legal bit clock.
    next_s.bclk_prev = bclk_q;
    if (bclk_q && !s.bclk_prev)
    begin
      next_s.mode_cnt = MODE_WINDOW;
      next_s.var_seen = 1'b1;
    end
    else if (s.mode_cnt != 12'h000)
      next_s.mode_cnt = s.mode_cnt - 12'h001;
    else
      next_s.var_seen = 1'b0;

    // Standby after the frame sync has stayed low long enough
    if (fs_q)
    begin
      next_s.sby_cnt = '0;
      next_s.standby = 1'b0;
    end
    else if (s.sby_cnt == SBY_LAST)
      next_s.standby = 1'b1;
    else
      next_s.sby_cnt = s.sby_cnt + SBY_W'(1);

    // Operating mode
    if (!pdn_q || !s.ctrl_en)
      next_s.mode = PCMRX_OFF;
    else if (s.standby)
      next_s.mode = PCMRX_STANDBY;
    else if (s.var_seen)
      next_s.mode = PCMRX_VARIABLE;
    else
      next_s.mode = PCMRX_FIXED;

    // Link words are always consumed so none turns up stale later
    next_s.word_valid = 1'b0;
    next_s.tog_seen = tog_q;

    // Word capture per mode
    unique case (s.mode)
      PCMRX_OFF:
      begin
        next_s.var_cnt = 3'h0;
        next_s.sig_bit = 1'b0; // Inactive port drops the signaling level
      end
      PCMRX_STANDBY:
        next_s.var_cnt = 3'h0;
      PCMRX_FIXED:
      begin
        next_s.var_cnt = 3'h0;
        if (tog_q != s.tog_seen)
        begin
          next_s.word = link_if.word;
          next_s.word_sig = link_if.sig_frame;
          next_s.word_valid = 1'b1;
          next_s.word_count = s.word_count + 16'h0001;
          if (link_if.sig_frame)
            next_s.sig_bit = link_if.word[0];
        end
      end
      PCMRX_VARIABLE:
      begin
        // Slot enable gates the bit count; a longer slot starts a new word
        if (!fs_q)
          next_s.var_cnt = 3'h0;
        else if (s.bclk_prev && !bclk_q)
        begin
          next_s.var_shift = {s.var_shift[6:0], dat_q};
          next_s.var_cnt = s.var_cnt + 3'h1;
          if (s.var_cnt == BIT_LAST)
          begin
            next_s.word = {s.var_shift[6:0], dat_q};
            next_s.word_sig = 1'b0;
            next_s.word_valid = 1'b1;
            next_s.word_count = s.word_count + 16'h0001;
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.ctrl_en <= CTRL_EN_RST;
      s.freq_code <= FSEL_NEG;
      s.mode <= PCMRX_OFF;
      s.bresp <= RESP_OKAY;
      s.rresp <= RESP_OKAY;
    end
    else
      s <= next_s;
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------------------------------
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign rx_signal_bit_out = s.sig_bit;
  assign rx_word = s.word;
  assign rx_word_valid = s.word_valid;
endmodule

// [sim/pcmrx_chk_sva.sv]
`timescale 1ns/10ps
module pcmrx_chk_sva
  import pcmrx_pkg::*;
#(
  parameter int STANDBY_CYCLES = 200
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic rx_bit_clock,
  input wire logic rx_frame_sync,
  input wire logic power_down_n,
  input wire logic [1:0] master_freq_select,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic rx_signal_bit_out,
  input wire logic [7:0] rx_word,
  input wire logic rx_word_valid
);
  // ----
  // Helpers
  // ----
  int fs_low;
  int bclk_age;
  logic [15:0] khz;
  logic rd_st;
  logic rd_fq;

  // Strap decode and read takes
  assign khz = (master_freq_select == FSEL_GND) ? KHZ_1544 : (master_freq_select == FSEL_POS) ? KHZ_1536 : KHZ_2048;
  assign rd_st = s_axi_arvalid && s_axi_arready && s_axi_araddr == REG_STATUS;
  assign rd_fq = s_axi_arvalid && s_axi_arready && s_axi_araddr == REG_FREQ;

  // Saturating counters, so a long idle never wraps
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fs_low <= 0;
      bclk_age <= 8191;
    end
    else
    begin
      fs_low <= rx_frame_sync ? 0 : (fs_low < 1000000 ? fs_low + 1 : fs_low);
      bclk_age <= $rose(rx_bit_clock) ? 0 : (bclk_age < 8191 ? bclk_age + 1 : bclk_age);
    end
  end

  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  chk_valid_pulse: assert property (rx_word_valid |=> !rx_word_valid)
    else $error("word valid longer than one cycle");
  chk_word_change: assert property ($changed(rx_word) |-> rx_word_valid)
    else $error("word changed without valid");
  chk_sig_hold: assert property ($changed(rx_signal_bit_out) && power_down_n |->
      rx_signal_bit_out == rx_word[0] && (rx_word_valid || $past(rx_word_valid)))
    else $error("signal bit moved without a word");
  chk_pdn_quiet: assert property (!power_down_n [*8] |-> !rx_signal_bit_out && !rx_word_valid)
    else $error("port active in power down");
  chk_freq_read: assert property (rd_fq |=> s_axi_rdata[15:0] == khz)
    else $error("clock rate does not match strap");
  chk_standby_on: assert property (rd_st && power_down_n && fs_low > STANDBY_CYCLES + 8 |=> s_axi_rdata[ST_SBY])
    else $error("no standby after long sync low");
  chk_fixed_mode: assert property (rd_st && bclk_age > 4000 |=> !s_axi_rdata[ST_VAR])
    else $error("variable timing with idle bit clock");
  chk_var_mode: assert property (rd_st && bclk_age inside {[8:3000]} |=> s_axi_rdata[ST_VAR])
    else $error("fixed timing with running bit clock");

  // Main scenarios reached
  cover property (rx_word_valid && rx_signal_bit_out);
  cover property (rd_st && fs_low > STANDBY_CYCLES + 8);
  cover property (rd_st && bclk_age < 3000);
endmodule

bind pcmrx_top pcmrx_chk_sva #(.STANDBY_CYCLES(STANDBY_CYCLES)) i_pcmrx_chk_sva (
  .clk_sys(clk_sys), .rst_n(rst_n), .rx_bit_clock(rx_bit_clock), .rx_frame_sync(rx_frame_sync),
  .power_down_n(power_down_n), .master_freq_select(master_freq_select), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .rx_signal_bit_out(rx_signal_bit_out), .rx_word(rx_word), .rx_word_valid(rx_word_valid)
);

// [sim/pcmrx_far_model.sv]
`timescale 1ns/10ps
module pcmrx_far_model (
  input wire logic rx_master_clock,
  output logic rx_bit_clock,
  output logic rx_frame_sync,
  output logic rx_pcm_data
);
  // 2 MHz bit clock, inside the allowed span
  localparam int HALF_NS = 250;

  // Idle: no sync, bit clock stopped low
  initial
  begin
    rx_bit_clock = 1'b0;
    rx_frame_sync = 1'b0;
    rx_pcm_data = 1'b0;
  end

  // Fixed frame, launched off the rising edge, away from the falling sampling edge
  task automatic send_fixed(input logic [7:0] w, input logic sig);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge rx_master_clock);
      rx_frame_sync <= (i == 7) || (sig && i == 6);
      rx_pcm_data <= w[i];
    end
    @(posedge rx_master_clock);
    rx_frame_sync <= 1'b0;
    rx_pcm_data <= ~w[0];
  endtask

  // Variable slot: enable held for the whole slot
  task automatic send_var(input logic [7:0] w);
    // Start off a master clock edge, and run one idle bit clock first so the
    // port has switched timing before the slot opens
    @(posedge rx_master_clock);
    rx_bit_clock = 1'b1;
    #(HALF_NS);
    rx_bit_clock = 1'b0;
    #(HALF_NS);
    for (int i = 7; i >= 0; i--)
    begin
      rx_bit_clock = 1'b1;
      rx_frame_sync = 1'b1;
      rx_pcm_data = w[i];
      #(HALF_NS);
      rx_bit_clock = 1'b0;
      #(HALF_NS);
    end
    rx_frame_sync = 1'b0;
    rx_pcm_data = ~w[0];
  endtask
endmodule

// [sim/test_pcm_codec_receive_port.sv]
`timescale 1ns/10ps
module test_pcm_codec_receive_port;
  import pcmrx_pkg::*;
  localparam int STBY = 200;
  logic clk_sys, rst_n, rx_master_clock, power_down_n, rx_bit_clock, rx_frame_sync, rx_pcm_data;
  logic [1:0] master_freq_select, bresp, rresp;
  logic [7:0] awaddr, araddr, rx_word;
  logic [31:0] wdata, rdata;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic rx_signal_bit_out, rx_word_valid;
  int err_count, n_checks;

  // ----
  // Clocks, start values, device
  // ----
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial
  begin
    rx_master_clock = 1'b0;
    #1.7;
    forever #3 rx_master_clock = ~rx_master_clock;
  end
  initial
  begin
    rst_n = 1'b0;
    power_down_n = 1'b1;
    master_freq_select = 2'h0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
  end
  pcmrx_far_model i_pcmrx_far_model (.rx_master_clock(rx_master_clock), .rx_bit_clock(rx_bit_clock),
    .rx_frame_sync(rx_frame_sync), .rx_pcm_data(rx_pcm_data));
  pcmrx_top #(.STANDBY_CYCLES(STBY)) i_pcmrx_top (.clk_sys(clk_sys), .rst_n(rst_n),
    .rx_master_clock(rx_master_clock), .rx_bit_clock(rx_bit_clock), .rx_frame_sync(rx_frame_sync),
    .rx_pcm_data(rx_pcm_data), .power_down_n(power_down_n), .master_freq_select(master_freq_select),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rx_signal_bit_out(rx_signal_bit_out), .rx_word(rx_word),
    .rx_word_valid(rx_word_valid));

  // ----
  // Shared tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic do_reset();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask
  // Address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    bit ta, tw;
    {ta, tw} = 2'b00;
    @(posedge clk_sys);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
    do
    begin
      @(posedge clk_sys);
      // Release each half by NBA so the slave never sees it drop mid-edge
      if (awready)
      begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready)
      begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!(ta && tw));
    do @(posedge clk_sys); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (!rvalid);
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
  endtask
  task automatic get_word(output logic [7:0] w);
    w = 'x;
    for (int i = 0; i < 2000; i++)
    begin
      @(posedge clk_sys);
      if (rx_word_valid === 1'b1)
      begin
        w = rx_word;
        break;
      end
    end
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] khz [3] = '{KHZ_2048, KHZ_1544, KHZ_1536};
    for (int k = 0; k < 3; k++)
    begin
      master_freq_select <= 2'(k);
      do_reset();
      axi_rd(REG_FREQ, d, r);
      chk(d[15:0], khz[k]);
      axi_rd(REG_STATUS, d, r);
      chk(d[7:0] & 8'hf1, {2'h2, 2'(k), 4'h0});
    end
    axi_rd(REG_CTRL, d, r);
    chk(d[0], CTRL_EN_RST);
    axi_rd(8'h10, d, r);
    chk(r, RESP_SLVERR);
    axi_wr(REG_CTRL, 32'h0, r);
    axi_rd(REG_STATUS, d, r);
    chk(d[7:6], 2'h0);
    axi_wr(REG_CTRL, 32'h1, r);
    chk(r, RESP_OKAY);
  endtask
  // Plain and signaling frames mixed, last two both signaling; signal bit follows only the latter
  task automatic t_fixed();
    logic [7:0] w;
    logic [7:0] words [5] = '{8'ha5, 8'h81, 8'h3c, 8'h3c, 8'h81};
    logic fl [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    logic exps;
    exps = 1'b0;
    for (int k = 0; k < 5; k++)
    begin
      fork
        i_pcmrx_far_model.send_fixed(words[k], fl[k]);
        get_word(w);
      join
      if (fl[k]) exps = words[k][0];
      repeat (3) @(posedge clk_sys);
      chk(w, words[k]);
      chk(rx_signal_bit_out, exps);
    end
  endtask
  task automatic t_pdn();
    logic [7:0] w;
    int n;
    n = 0;
    @(posedge clk_sys);
    power_down_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    fork
      i_pcmrx_far_model.send_fixed(8'hff, 1'b1);
      repeat (40) @(posedge clk_sys) n += int'(rx_word_valid);
    join
    chk(n, 0);
    chk(rx_signal_bit_out, 1'b0);
    power_down_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
    fork
      i_pcmrx_far_model.send_fixed(8'h42, 1'b0);
      get_word(w);
    join
    chk(w, 8'h42);
  endtask
  task automatic t_standby();
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] w;
    repeat (STBY + 20) @(posedge clk_sys);
    axi_rd(REG_STATUS, d, r);
    chk(d[7:0] & 8'hc2, 8'h42);
    // Double-length sync is always seen by the system clock; LSB 0 keeps the signal bit low
    fork
      i_pcmrx_far_model.send_fixed(8'h10, 1'b1);
      get_word(w);
    join
    chk(w, 8'h10);
    axi_rd(REG_STATUS, d, r);
    chk(d[7:0] & 8'hc2, 8'h80);
  endtask
  task automatic t_var();
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] w;
    fork
      i_pcmrx_far_model.send_var(8'h5f);
      get_word(w);
    join
    chk(w, 8'h5f);
    axi_rd(REG_STATUS, d, r);
    chk(d[7:0] & 8'hc9, 8'hc1);
    chk(rx_signal_bit_out, 1'b0);
  endtask

  // ----
  // Sequence and verdict
  // ----
  task automatic final_report();
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #150000;
    err_count++;
    final_report();
  end
  initial
  begin
    t_regs();
    $display("registers test ended");
    t_fixed();
    $display("fixed timing test ended");
    t_pdn();
    $display("power down test ended");
    t_standby();
    $display("standby test ended");
    t_var();
    $display("variable timing test ended");
    final_report();
  end
endmodule
